// ==== logic/nbep_bad_table.sv ====
`timescale 1ns/1ps
module nbep_bad_table
    import nbep_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Marking port
    input wire logic mark,
    input wire logic [BLK_W-1:0] mark_blk,
    // Lookup ports
    input wire logic [BLK_W-1:0] look_blk,
    output logic look_bad,
    input wire logic [BLK_W-1:0] chk_blk,
    output logic chk_bad,
    // Totals
    output logic [CNT_W-1:0] bad_cnt,
    output logic over_limit
);

    typedef struct packed {
        logic [NUM_BLOCKS-1:0] bad;
        logic [CNT_W-1:0] cnt;
        logic over;
    } nbep_tbl_s;

    nbep_tbl_s tbl_r;
    nbep_tbl_s tbl_nxt;
    logic [NUM_BLOCKS-1:0] set_vec;

    genvar i;
    generate
        for (i = 0; i < NUM_BLOCKS; i++) begin : g_entry
            assign set_vec[i] = mark && (mark_blk == BLK_W'(i));
        end
    endgenerate

    always_comb begin
        tbl_nxt = tbl_r;
        tbl_nxt.bad = tbl_r.bad | set_vec;
        if (mark && !tbl_r.bad[mark_blk]) begin
            tbl_nxt.cnt = tbl_r.cnt + CNT_W'(1);
        end
        // A count past this means the part is worn beyond its rated spare pool.
        tbl_nxt.over = tbl_nxt.cnt > MAX_BAD_BLOCKS;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tbl_r <= '0;
        end else begin
            tbl_r <= tbl_nxt;
        end
    end

    assign look_bad = tbl_r.bad[look_blk];
    assign chk_bad = tbl_r.bad[chk_blk];
    assign bad_cnt = tbl_r.cnt;
    assign over_limit = tbl_r.over;

    chk_over_flag: assert property (@(posedge clk) disable iff (!nrst)
        (tbl_r.cnt > MAX_BAD_BLOCKS) |-> tbl_r.over)
        else $error("over limit flag missing");

endmodule : nbep_bad_table

// ==== logic/nbep_host_ctrl.sv ====
`timescale 1ns/1ps
module nbep_host_ctrl
    import nbep_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // User request
    input wire logic usr_req,
    input wire logic [1:0] usr_op,
    input wire logic [BLK_W-1:0] usr_blk,
    input wire logic [PAGE_W-1:0] usr_page,
    input wire logic [COL_W-1:0] usr_col,
    input wire logic [7:0] usr_wdata,
    input wire logic usr_pad,
    // User answer
    output logic usr_ready,
    output logic usr_done,
    output logic usr_fail,
    output logic usr_rejected,
    output logic [7:0] usr_rdata,
    output logic usr_reload,
    output logic [BLK_W-1:0] usr_new_blk,
    // ECC report
    input wire logic ecc_valid,
    input wire logic [4:0] ecc_nerr,
    output logic ecc_rewrite,
    output logic ecc_uncorr,
    // Table state
    output logic scan_done,
    output logic [CNT_W-1:0] bad_count,
    output logic bad_over_limit,
    // Flash link
    output logic nf_req,
    output logic [7:0] nf_cmd,
    output logic [BLK_W-1:0] nf_blk,
    output logic [PAGE_W-1:0] nf_page,
    output logic [COL_W-1:0] nf_col,
    output logic [7:0] nf_wdata,
    input wire logic nf_ack,
    input wire logic [7:0] nf_rdata
);

    typedef struct packed {
        nbep_state_e st;
        logic [1:0] op;
        logic pad;
        logic [BLK_W-1:0] scan_blk;
        logic [BLK_W-1:0] cand;
        logic [BLK_W-1:0] wear_ptr;
        logic [CNT_W-1:0] hops;
        logic pp_valid;
        logic [BLK_W-1:0] pp_blk;
        logic [PAGE_W-1:0] pp_page;
        logic [2:0] pp_cnt;
        logic usr_ready;
        logic usr_done;
        logic usr_fail;
        logic usr_rejected;
        logic [7:0] usr_rdata;
        logic usr_reload;
        logic [BLK_W-1:0] usr_new_blk;
        logic ecc_rewrite;
        logic ecc_uncorr;
        logic scan_done;
        logic nf_req;
        logic [7:0] nf_cmd;
        logic [BLK_W-1:0] nf_blk;
        logic [PAGE_W-1:0] nf_page;
        logic [COL_W-1:0] nf_col;
        logic [7:0] nf_wdata;
    } nbep_ctrl_s;

    nbep_ctrl_s s_r;
    nbep_ctrl_s s_nxt;
    logic tbl_mark;
    logic [BLK_W-1:0] tbl_mark_blk;
    logic [BLK_W-1:0] look_blk;
    logic look_bad;
    logic chk_bad;
    logic same_page;

    // ************************************************************
    // Bad block table
    // ************************************************************
    nbep_bad_table u_table (
        .clk(clk),
        .nrst(nrst),
        .mark(tbl_mark),
        .mark_blk(tbl_mark_blk),
        .look_blk(look_blk),
        .look_bad(look_bad),
        .chk_blk(s_r.nf_blk),
        .chk_bad(chk_bad),
        .bad_cnt(bad_count),
        .over_limit(bad_over_limit)
    );

    assign look_blk = (s_r.st == ST_SPARE) ? s_r.cand : s_r.nf_blk;
    assign same_page = s_r.pp_valid && (s_r.pp_blk == s_r.nf_blk) && (s_r.pp_page == s_r.nf_page);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        tbl_mark = 1'b0;
        tbl_mark_blk = s_r.nf_blk;
        s_nxt.usr_done = 1'b0;
        s_nxt.usr_rejected = 1'b0;
        s_nxt.usr_reload = 1'b0;
        // Correctable errors only advise a rewrite; they never retire a block.
        s_nxt.ecc_uncorr = ecc_valid && (ecc_nerr > ECC_MAX_CORR);
        s_nxt.ecc_rewrite = ecc_valid && (ecc_nerr >= ECC_REWRITE_AT)
            && (ecc_nerr <= ECC_MAX_CORR);
        unique case (s_r.st)
            ST_SCAN: begin
                if (!s_r.nf_req) begin
                    s_nxt.nf_req = 1'b1;
                    s_nxt.nf_cmd = CMD_READ;
                    s_nxt.nf_blk = s_r.scan_blk;
                    s_nxt.nf_page = SCAN_PAGE;
                    s_nxt.nf_col = SCAN_COL;
                end else if (nf_ack) begin
                    s_nxt.nf_req = 1'b0;
                    tbl_mark = (nf_rdata == BAD_MARK);
                    tbl_mark_blk = s_r.scan_blk;
                    s_nxt.scan_blk = s_r.scan_blk + BLK_W'(1);
                    if (s_r.scan_blk == LAST_BLOCK) begin
                        s_nxt.st = ST_IDLE;
                        s_nxt.scan_done = 1'b1;
                        s_nxt.usr_ready = 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                if (usr_req) begin
                    s_nxt.usr_ready = 1'b0;
                    s_nxt.op = usr_op;
                    s_nxt.pad = usr_pad;
                    s_nxt.nf_blk = usr_blk;
                    s_nxt.nf_page = usr_page;
                    s_nxt.nf_col = usr_col;
                    s_nxt.nf_wdata = usr_pad ? PAD_FILL : usr_wdata;
                    s_nxt.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // Retired blocks are refused outright; erasing one could wipe its mark.
                if (look_bad || (s_r.op == OP_PROG && same_page && s_r.pp_cnt == PP_MAX)
                        || s_r.op == 2'h3) begin
                    s_nxt.usr_rejected = 1'b1;
                    s_nxt.usr_done = 1'b1;
                    s_nxt.usr_fail = 1'b1;
                    s_nxt.usr_ready = 1'b1;
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.nf_req = 1'b1;
                    s_nxt.nf_cmd = (s_r.op == OP_READ) ? CMD_READ :
                        (s_r.op == OP_PROG) ? CMD_PROG : CMD_ERASE;
                    if (s_r.op == OP_PROG) begin
                        s_nxt.pp_valid = 1'b1;
                        s_nxt.pp_blk = s_r.nf_blk;
                        s_nxt.pp_page = s_r.nf_page;
                        s_nxt.pp_cnt = same_page ? s_r.pp_cnt + 3'h1 : 3'h1;
                    end
                    s_nxt.st = ST_OP;
                end
            end
            ST_OP: begin
                if (!s_r.nf_req) begin
                    s_nxt.nf_req = 1'b1;
                    s_nxt.nf_cmd = CMD_PROG;
                end else if (nf_ack) begin
                    s_nxt.nf_req = 1'b0;
                    if (s_r.op == OP_READ) begin
                        s_nxt.usr_rdata = nf_rdata;
                        s_nxt.usr_done = 1'b1;
                        s_nxt.usr_fail = 1'b0;
                        s_nxt.usr_ready = 1'b1;
                        s_nxt.st = ST_IDLE;
                    end else begin
                        s_nxt.st = ST_STATUS;
                    end
                end
            end
            ST_STATUS: begin
                if (!s_r.nf_req) begin
                    s_nxt.nf_req = 1'b1;
                    s_nxt.nf_cmd = CMD_STATUS;
                end else if (nf_ack) begin
                    s_nxt.nf_req = 1'b0;
                    if (nf_rdata[STAT_FAIL_BIT]) begin
                        tbl_mark = 1'b1;
                        if (s_r.op == OP_PROG) begin
                            // The failed block is retired; pick a spare from the wear pointer.
                            s_nxt.usr_reload = 1'b1;
                            s_nxt.cand = s_r.wear_ptr;
                            s_nxt.hops = '0;
                            s_nxt.st = ST_SPARE;
                        end else begin
                            s_nxt.usr_done = 1'b1;
                            s_nxt.usr_fail = 1'b1;
                            s_nxt.usr_ready = 1'b1;
                            s_nxt.st = ST_IDLE;
                        end
                    end else begin
                        if (s_r.op == OP_ERASE && s_r.pp_blk == s_r.nf_blk) begin
                            s_nxt.pp_valid = 1'b0;
                        end
                        s_nxt.usr_new_blk = s_r.nf_blk;
                        s_nxt.usr_done = 1'b1;
                        s_nxt.usr_fail = 1'b0;
                        s_nxt.usr_ready = 1'b1;
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_SPARE: begin
                if (s_r.hops == SPARE_HOPS) begin
                    s_nxt.usr_done = 1'b1;
                    s_nxt.usr_fail = 1'b1;
                    s_nxt.usr_ready = 1'b1;
                    s_nxt.st = ST_IDLE;
                end else if (look_bad) begin
                    s_nxt.cand = s_r.cand + BLK_W'(1);
                    s_nxt.hops = s_r.hops + CNT_W'(1);
                end else begin
                    s_nxt.nf_blk = s_r.cand;
                    s_nxt.wear_ptr = s_r.cand + BLK_W'(1);
                    s_nxt.pp_valid = 1'b1;
                    s_nxt.pp_blk = s_r.cand;
                    s_nxt.pp_page = s_r.nf_page;
                    s_nxt.pp_cnt = 3'h1;
                    s_nxt.st = ST_OP;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign usr_ready = s_r.usr_ready;
    assign usr_done = s_r.usr_done;
    assign usr_fail = s_r.usr_fail;
    assign usr_rejected = s_r.usr_rejected;
    assign usr_rdata = s_r.usr_rdata;
    assign usr_reload = s_r.usr_reload;
    assign usr_new_blk = s_r.usr_new_blk;
    assign ecc_rewrite = s_r.ecc_rewrite;
    assign ecc_uncorr = s_r.ecc_uncorr;
    assign scan_done = s_r.scan_done;
    assign nf_req = s_r.nf_req;
    assign nf_cmd = s_r.nf_cmd;
    assign nf_blk = s_r.nf_blk;
    assign nf_page = s_r.nf_page;
    assign nf_col = s_r.nf_col;
    assign nf_wdata = s_r.nf_wdata;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence op_end_s;
        nf_req && nf_ack && (nf_cmd == CMD_PROG || nf_cmd == CMD_ERASE);
    endsequence
    sequence stat_issue_s;
        !nf_req ##1 (nf_req && nf_cmd == CMD_STATUS);
    endsequence
    sequence stat_fail_s;
        nf_req && nf_ack && nf_cmd == CMD_STATUS && nf_rdata[0] && !chk_bad;
    endsequence

    chk_erase_good_only: assert property ((nf_req && nf_cmd == CMD_ERASE) |-> !chk_bad)
        else $error("erase issued to retired block");
    chk_status_after_op: assert property (op_end_s |=> stat_issue_s)
        else $error("no status read after program or erase");
    chk_fail_retires: assert property (stat_fail_s
        |=> bad_count == $past(bad_count) + 11'h001)
        else $error("failed block not retired");
    chk_prog_fail_reload: assert property ((stat_fail_s and s_r.op == OP_PROG)
        |=> usr_reload)
        else $error("program failure without reload");
    chk_pp_bound: assert property (s_r.pp_cnt <= PP_MAX)
        else $error("partial program count above limit");
    chk_scan_mark: assert property ((s_r.st == ST_SCAN && nf_req && nf_ack
        && nf_rdata == BAD_MARK && !chk_bad) |=> bad_count == $past(bad_count) + 11'h001)
        else $error("scan marker not recorded");
    chk_scan_gate: assert property (!scan_done |-> !usr_ready)
        else $error("requests open before scan end");
    chk_reject_bad: assert property ((s_r.st == ST_CHECK && look_bad)
        |=> usr_rejected && usr_done && !nf_req)
        else $error("retired block not refused");
    chk_prog_good_only: assert property ((nf_req && nf_cmd == CMD_PROG) |-> !chk_bad)
        else $error("program issued to retired block");
    chk_ecc_uncorr: assert property ((ecc_valid && ecc_nerr > ECC_MAX_CORR)
        |=> ecc_uncorr && !ecc_rewrite)
        else $error("uncorrectable report wrong");
    chk_ecc_rewrite: assert property ((ecc_valid && ecc_nerr >= ECC_REWRITE_AT
        && ecc_nerr <= ECC_MAX_CORR) |=> ecc_rewrite && !ecc_uncorr)
        else $error("rewrite advice missing");
    chk_ecc_no_retire: assert property ((ecc_valid && s_r.st == ST_IDLE && !usr_req)
        |=> $stable(bad_count))
        else $error("block retired on ECC report");
    chk_pad_ones: assert property ((nf_req && nf_cmd == CMD_PROG && s_r.pad)
        |-> nf_wdata == PAD_FILL)
        else $error("padding not all ones");
    chk_wear_moves: assert property ((s_r.st == ST_SPARE && !look_bad
        && s_r.hops != SPARE_HOPS) |=> s_r.wear_ptr == $past(s_r.cand) + 10'h001)
        else $error("wear pointer did not advance");

endmodule : nbep_host_ctrl

// ==== logic/nbep_pkg.sv ====
// How it works
// - At most four partial programs per page; only the last programmed page is counted.
// - Never erase a block marked bad.
// - Scan all blocks after install; retire bad.
// - Read marker column; 00h means bad block.
// - Status read after erase; fail means replace.
// - Status read after program; fail means replace.
// - Program fail: reload, rewrite elsewhere, retire.
// - Erase fail: record block, block later access.
// - ECC corrects eight bits per 512 bytes.
// - Rewrite data before errors become uncorrectable.
// - Retire only on status fail, not ECC.
// - Spread spare use evenly across blocks.
// - Pad unused page areas with ones.
// - Status comes back after command 70h.
package nbep_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int unsigned NUM_BLOCKS = 1024;
    localparam int unsigned BLK_W = 10;
    localparam int unsigned PAGE_W = 6;
    localparam int unsigned COL_W = 12;
    localparam int unsigned CNT_W = 11;
    localparam int unsigned MIN_GOOD_BLOCKS = 1004;
    localparam logic [CNT_W-1:0] MAX_BAD_BLOCKS = CNT_W'(NUM_BLOCKS - MIN_GOOD_BLOCKS);
    localparam logic [BLK_W-1:0] LAST_BLOCK = BLK_W'(NUM_BLOCKS - 1);
    localparam logic [CNT_W-1:0] SPARE_HOPS = CNT_W'(NUM_BLOCKS);

    // ************************************************************
    // Policy figures
    // ************************************************************
    localparam logic [2:0] PP_MAX = 3'h4;
    localparam int unsigned ECC_UNIT_BYTES = 512;
    localparam logic [4:0] ECC_MAX_CORR = 5'h08;
    localparam logic [4:0] ECC_REWRITE_AT = 5'h06;
    localparam logic [7:0] BAD_MARK = 8'h00;
    localparam logic [7:0] PAD_FILL = 8'hff;
    localparam logic [PAGE_W-1:0] SCAN_PAGE = 6'h00;
    localparam logic [COL_W-1:0] SCAN_COL = 12'h800;
    localparam int unsigned STAT_FAIL_BIT = 0;

    // ************************************************************
    // Command bytes
    // ************************************************************
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    // ************************************************************
    // Types
    // ************************************************************
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;

    typedef enum logic [2:0] {
        ST_SCAN,
        ST_IDLE,
        ST_CHECK,
        ST_OP,
        ST_STATUS,
        ST_SPARE
    } nbep_state_e;

endpackage : nbep_pkg

// ==== testbench/nbep_flash_model.sv ====
`timescale 1ns/1ps
module nbep_flash_model
    import nbep_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Answer speed
    input wire logic slow,
    // Flash link
    input wire logic nf_req,
    input wire logic [7:0] nf_cmd,
    input wire logic [BLK_W-1:0] nf_blk,
    input wire logic [PAGE_W-1:0] nf_page,
    input wire logic [COL_W-1:0] nf_col,
    input wire logic [7:0] nf_wdata,
    output logic nf_ack,
    output logic [7:0] nf_rdata
);
    // ****************
    // Array state
    // ****************
    bit factory_bad [NUM_BLOCKS];
    bit prog_fail [NUM_BLOCKS];
    bit erase_fail [NUM_BLOCKS];
    bit retired [NUM_BLOCKS];
    int pp_cnt [int];
    int viol_cnt = 0;
    int wait_c;
    logic [7:0] last_wdata;
    logic [BLK_W-1:0] op_blk;
    bit pend;
    bit fail;
    // ****************
    // Command handling
    // ****************
    always @(posedge clk) begin
        nf_ack <= 1'b0;
        // A released bus must never look like data that is still held.
        nf_rdata <= ~nf_rdata;
        if (!nrst) begin
            wait_c <= 0;
            pend <= 1'b0;
            nf_rdata <= 8'h5a;
        end else if (nf_req && !nf_ack) begin
            if (wait_c < (slow ? 3 : 0)) begin
                wait_c <= wait_c + 1;
            end else begin
                wait_c <= 0;
                nf_ack <= 1'b1;
                if (pend && nf_cmd !== CMD_STATUS) viol_cnt++;
                if (nf_cmd !== CMD_STATUS && retired[nf_blk]) viol_cnt++;
                case (nf_cmd)
                    CMD_READ: begin
                        nf_rdata <= factory_bad[nf_blk] ? BAD_MARK :
                            (nf_col == SCAN_COL) ? 8'hff :
                            nf_blk[7:0] ^ nf_col[7:0] ^ {2'h0, nf_page};
                    end
                    CMD_PROG: begin
                        if (factory_bad[nf_blk]) viol_cnt++;
                        pp_cnt[{nf_blk, nf_page}]++;
                        if (pp_cnt[{nf_blk, nf_page}] > 4) viol_cnt++;
                        fail <= prog_fail[nf_blk];
                        op_blk <= nf_blk;
                        pend <= 1'b1;
                        last_wdata <= nf_wdata;
                    end
                    CMD_ERASE: begin
                        if (factory_bad[nf_blk]) viol_cnt++;
                        for (int p = 0; p < 64; p++) pp_cnt.delete({nf_blk, 6'(p)});
                        fail <= erase_fail[nf_blk];
                        op_blk <= nf_blk;
                        pend <= 1'b1;
                    end
                    CMD_STATUS: begin
                        nf_rdata <= {7'h70, fail};
                        if (pend && fail) retired[op_blk] = 1'b1;
                        pend <= 1'b0;
                    end
                    default: viol_cnt++;
                endcase
            end
        end
    end
endmodule : nbep_flash_model

// ==== testbench/test_nbep_host_ctrl.sv ====
`timescale 1ns/1ps
module test_nbep_host_ctrl
    import nbep_pkg::*;
;
    // ****************
    // Signals
    // ****************
    logic clk = 0, nrst = 0, slow = 0, usr_req = 0, usr_pad = 0, ecc_valid = 0;
    logic [1:0] usr_op = 0;
    logic [BLK_W-1:0] usr_blk = 0;
    logic [PAGE_W-1:0] usr_page = 0;
    logic [COL_W-1:0] usr_col = 0;
    logic [7:0] usr_wdata = 0;
    logic [4:0] ecc_nerr = 0;
    logic usr_ready, usr_done, usr_fail, usr_rejected, usr_reload;
    logic ecc_rewrite, ecc_uncorr, scan_done, bad_over_limit, nf_req, nf_ack;
    logic [7:0] usr_rdata, nf_cmd, nf_wdata, nf_rdata;
    logic [BLK_W-1:0] usr_new_blk, nf_blk;
    logic [CNT_W-1:0] bad_count;
    logic [PAGE_W-1:0] nf_page;
    logic [COL_W-1:0] nf_col;
    int fail_count = 0, samples_checked = 0, seed, reload_n = 0, rew_n = 0, unc_n = 0;
    int exp_cnt = 0, pp_key = -1, pp = 0, g, g2, g3, bb, i, n, r0, w0, u0;
    bit exp_bad [NUM_BLOCKS];
    int bnd [4] = '{5, 6, 8, 9};

    always #20 clk = ~clk;

    nbep_host_ctrl nbep_host_ctrl_inst (.clk(clk), .nrst(nrst), .usr_req(usr_req),
        .usr_op(usr_op), .usr_blk(usr_blk), .usr_page(usr_page), .usr_col(usr_col),
        .usr_wdata(usr_wdata), .usr_pad(usr_pad), .usr_ready(usr_ready), .usr_done(usr_done),
        .usr_fail(usr_fail), .usr_rejected(usr_rejected), .usr_rdata(usr_rdata),
        .usr_reload(usr_reload), .usr_new_blk(usr_new_blk), .ecc_valid(ecc_valid),
        .ecc_nerr(ecc_nerr), .ecc_rewrite(ecc_rewrite), .ecc_uncorr(ecc_uncorr),
        .scan_done(scan_done), .bad_count(bad_count), .bad_over_limit(bad_over_limit),
        .nf_req(nf_req), .nf_cmd(nf_cmd), .nf_blk(nf_blk), .nf_page(nf_page),
        .nf_col(nf_col), .nf_wdata(nf_wdata), .nf_ack(nf_ack), .nf_rdata(nf_rdata));

    nbep_flash_model nbep_flash_model_inst (.clk(clk), .nrst(nrst), .slow(slow),
        .nf_req(nf_req), .nf_cmd(nf_cmd), .nf_blk(nf_blk), .nf_page(nf_page),
        .nf_col(nf_col), .nf_wdata(nf_wdata), .nf_ack(nf_ack), .nf_rdata(nf_rdata));

    // Pulses are counted here so that a stretched or lost pulse shows as a wrong count.
    always @(posedge clk) begin
        reload_n += (usr_reload === 1'b1);
        rew_n += (ecc_rewrite === 1'b1);
        unc_n += (ecc_uncorr === 1'b1);
    end

    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic run(input int op, input int b, input int p, input int c, input bit pad,
                       input bit ef);
        int k;
        bit rej;
        k = 0;
        rej = (op == 3) || exp_bad[b] || (op == 1 && b * 64 + p == pp_key && pp >= 4);
        while (usr_ready !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 100) fail_count++;
        usr_req = 1;
        usr_op = 2'(op);
        usr_blk = BLK_W'(b);
        usr_page = PAGE_W'(p);
        usr_col = COL_W'(c);
        usr_pad = pad;
        usr_wdata = 8'($random(seed));
        @(posedge clk);
        #1;
        usr_req = 0;
        k = 0;
        while (usr_done !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 3000) fail_count++;
        check(usr_rejected, rej);
        check(usr_ready, 1'b1);
        if (!rej) begin
            check(usr_fail, ef);
            if (op == 0) begin
                check(usr_rdata, c == SCAN_COL ? 8'hff : b[7:0] ^ c[7:0] ^ p[7:0]);
            end
            if (op == 1) pp = (b * 64 + p == pp_key) ? pp + 1 : 1;
            if (op == 1) pp_key = b * 64 + p;
            if (op == 2 && b == pp_key / 64) pp = 0;
        end
    endtask : run

    // ****************
    // Main sequence
    // ****************
    initial begin
        #(40 * 40000);
        fail_count++;
        results();
    end

    initial begin
        seed = 26937;
        for (i = 0; i < 6; i++) begin
            bb = {$random(seed)} % NUM_BLOCKS;
            nbep_flash_model_inst.factory_bad[bb] = 1;
            exp_bad[bb] = 1;
        end
        foreach (exp_bad[j]) exp_cnt += exp_bad[j];
        repeat (5) @(posedge clk);
        #1;
        nrst = 1;
        for (n = 0; n < 20000 && scan_done !== 1'b1; n++) @(posedge clk);
        #1;
        check(scan_done, 1'b1);
        check(bad_count, exp_cnt);
        check(bad_over_limit, 1'b0);
        $display("test scan done");
        for (g = 100; exp_bad[g]; g++);
        for (g2 = g + 1; exp_bad[g2]; g2++);
        for (g3 = g2 + 1; exp_bad[g3]; g3++);
        slow = 1;
        run(0, g, {$random(seed)} % 64, {$random(seed)} % 2048, 0, 0);
        run(0, g, 3, SCAN_COL, 0, 0);
        run(0, bb, 0, 0, 0, 0);
        slow = 0;
        run(2, bb, 0, 0, 0, 0);
        run(1, bb, 0, 0, 0, 0);
        run(3, g, 0, 0, 0, 0);
        $display("test access done");
        run(1, g, 1, 0, 1, 0);
        check(nbep_flash_model_inst.last_wdata, PAD_FILL);
        run(1, g, 1, 5, 0, 0);
        check(nbep_flash_model_inst.last_wdata, usr_wdata);
        for (i = 0; i < 5; i++) run(1, g, 2, i * 16, 0, 0);
        run(2, g, 0, 0, 0, 0);
        run(1, g, 2, 0, 0, 0);
        check(usr_new_blk, g);
        $display("test program done");
        nbep_flash_model_inst.prog_fail[g2] = 1;
        r0 = reload_n;
        run(1, g2, 0, 0, 0, 0);
        check(reload_n - r0, 1);
        exp_bad[g2] = 1;
        exp_cnt++;
        check(bad_count, exp_cnt);
        check(exp_bad[usr_new_blk], 1'b0);
        pp_key = -1;
        run(0, g2, 0, 0, 0, 0);
        nbep_flash_model_inst.erase_fail[g3] = 1;
        run(2, g3, 0, 0, 0, 1);
        exp_bad[g3] = 1;
        exp_cnt++;
        check(bad_count, exp_cnt);
        run(2, g3, 0, 0, 0, 0);
        $display("test failure done");
        for (i = 0; i < 16; i++) begin
            n = (i < 4) ? bnd[i] : {$random(seed)} % 32;
            r0 = bad_count;
            w0 = rew_n;
            u0 = unc_n;
            ecc_valid = 1;
            ecc_nerr = 5'(n);
            @(posedge clk);
            #1;
            ecc_valid = 0;
            repeat (3) @(posedge clk);
            #1;
            check(rew_n - w0, n >= 6 && n <= 8);
            check(unc_n - u0, n > 8);
            check(bad_count, r0);
        end
        $display("test ecc done");
        check(nbep_flash_model_inst.viol_cnt, 0);
        results();
    end
endmodule : test_nbep_host_ctrl
